/* File: shared/fault_diag_pkg.sv */
// Constants, register map and carrier types of the fault diagnostic block.
// Assumes an APB master on pclk and ADC results delivered on the same clock.
package fault_diag_pkg;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CMD = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_TEMP_LIMIT = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_FAULT_SETUP = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_FAULT_STATUS = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_OT_FAULT = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_CHK_STORED = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_SIG_NVM = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_SIG_CALC = 8'h1c;
    localparam logic [ADDR_W-1:0] ADDR_REF_VOLT = 8'h20;
    localparam logic [ADDR_W-1:0] ADDR_COEF_A = 8'h24;
    localparam logic [ADDR_W-1:0] ADDR_COEF_B = 8'h28;
    localparam logic [ADDR_W-1:0] ADDR_COEF_C = 8'h2c;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h30;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h34;
    localparam logic [ADDR_W-1:0] ADDR_CFG_BASE = 8'h40;
    localparam int CFG_IDX_LSB = 2;
    localparam int CFG_IDX_W = 3;
    localparam int CFG_WORDS = 8;
    localparam int CMD_SCAN_BIT = 0;
    localparam int CMD_CALC_BIT = 1;
    localparam int CMD_CHECK_BIT = 2;
    localparam int CMD_RELOAD_BIT = 3;
    localparam int N_TEMP = 4;
    localparam int TEMP_W = 14;
    localparam logic [TEMP_W-1:0] TEMP_FULL_SCALE = 14'h3fff;
    localparam int TEMP_FULL_SCALE_MV = 2500;
    localparam logic [TEMP_W-1:0] TEMP_LIMIT_RST = 14'h0000;
    localparam logic [N_TEMP-1:0] TEST_SEL_RST = 4'h0;
    localparam int FS_OT_BIT = 0;
    localparam int FS_CHK_BIT = 1;
    localparam int FS_W = 2;
    localparam int IRQ_SCAN_BIT = 0;
    localparam int IRQ_CALC_BIT = 1;
    localparam int IRQ_LOAD_BIT = 2;
    localparam int IRQ_FAULT_BIT = 3;
    localparam int IRQ_W = 4;
    localparam int SIG_W = 16;
    localparam logic [SIG_W-1:0] SIG_POLY = 16'h1021;
    localparam int COEF_A_W = 9;
    localparam int COEF_A_SHIFT = 5;

    typedef logic [CFG_WORDS-1:0][TEMP_W-1:0] nvm_image_t;

    typedef struct packed {
        logic [N_TEMP-1:0][TEMP_W-1:0] volts;
        logic [TEMP_W-1:0] ref_volt;
    } adc_result_t;

    typedef struct packed {
        logic chk;
        logic ot;
    } fault_report_t;

    typedef enum logic [3:0] {
        MODE_IDLE = 4'b0001,
        MODE_CALC = 4'b0010,
        MODE_CHECK = 4'b0100,
        MODE_LOAD = 4'b1000
    } eng_mode_t;
endpackage

/* File: hw/sig_engine.sv */
// Serial signature engine: folds a word sequence into a shift signature.
// Assumes the caller supplies word_in for the index it shows, same cycle.
`timescale 1ns/1ps
`default_nettype none
module sig_engine #(
    parameter int WORD_W = 14,
    parameter int SIG_W = 16,
    parameter int N_WORDS = 8,
    parameter int IDX_W = 3,
    parameter logic [SIG_W-1:0] POLY = 16'h1021
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [WORD_W-1:0] word_in,
    output logic [IDX_W-1:0] idx,
    output logic busy,
    output logic done,
    output logic [SIG_W-1:0] sig
);
    localparam logic [IDX_W-1:0] LAST = IDX_W'(N_WORDS - 1);
    logic [SIG_W-1:0] step;

    always_comb begin
        step = {sig[SIG_W-2:0], 1'b0} ^ (sig[SIG_W-1] ? POLY : '0);
        step = step ^ SIG_W'(word_in);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            done <= 1'b0;
            idx <= '0;
            sig <= '0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                busy <= 1'b1;
                idx <= '0;
                sig <= '0;
            end else if (busy) begin
                sig <= step;
                idx <= idx + 1'b1;
                if (idx == LAST) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule // sig_engine
`default_nettype wire

/* File: hw/fault_diag.sv */
// Fault diagnostic block: over-temperature check, config checksum,
// memory image signature and reference data, behind an APB slave.
// Assumes ADC results and report_ack are synchronous to pclk.
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module fault_diag #(
    parameter fault_diag_pkg::nvm_image_t NVM_IMAGE = '0,
    // Stored image signature; value is arbitrary
    parameter logic [fault_diag_pkg::SIG_W-1:0] NVM_SIG = 16'h0000,
    parameter logic signed [fault_diag_pkg::COEF_A_W-1:0] COEF_A = 9'h000,
    parameter logic signed [fault_diag_pkg::TEMP_W-1:0] COEF_B = 14'h0000,
    parameter logic signed [fault_diag_pkg::TEMP_W-1:0] COEF_C = 14'h0000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [fault_diag_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire fault_diag_pkg::adc_result_t adc_in,
    output logic irq,
    output logic report_valid,
    output fault_diag_pkg::fault_report_t report_data,
    input wire logic report_ack
);
    import fault_diag_pkg::*;

    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [31:0] rdata_d;
    logic addr_ok;
    logic acc;
    logic acc_wr;
    logic acc_rd;
    logic [TEMP_W-1:0] limit_q;
    logic [N_TEMP-1:0] sel_q;
    logic [N_TEMP-1:0] ot_q;
    logic [N_TEMP-1:0] ot_hit;
    logic [N_TEMP-1:0] ot_clr;
    logic [FS_W-1:0] fs_q;
    logic [FS_W-1:0] fs_set;
    logic [FS_W-1:0] fs_clr;
    logic [TEMP_W-1:0] ref_q;
    logic [SIG_W-1:0] chk_stored_q;
    logic [SIG_W-1:0] sig_calc_q;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_mask_q;
    logic [IRQ_W-1:0] irq_ev;
    logic [IRQ_W-1:0] irq_clr;
    logic [TEMP_W-1:0] cfg_q [CFG_WORDS];
    logic report_valid_q;
    fault_report_t report_data_q;
    eng_mode_t mode_q;
    logic boot_q;
    logic scan_go;
    logic calc_go;
    logic check_go;
    logic load_go;
    logic cfg_hit;
    logic [CFG_IDX_W-1:0] cfg_idx;
    logic [CFG_IDX_W-1:0] eng_idx;
    logic eng_busy;
    logic eng_done;
    logic [SIG_W-1:0] eng_sig;
    logic [TEMP_W-1:0] eng_word;
    logic chk_fail;

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign report_valid = report_valid_q;
    assign report_data = report_data_q;

    ////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, answer registered

    assign acc = psel && penable && pready_q;
    assign acc_wr = acc && pwrite;
    assign acc_rd = acc && !pwrite;
    assign cfg_hit = paddr[ADDR_W-1:CFG_IDX_LSB+CFG_IDX_W] ==
        ADDR_CFG_BASE[ADDR_W-1:CFG_IDX_LSB+CFG_IDX_W] &&
        paddr[CFG_IDX_LSB-1:0] == '0;
    assign cfg_idx = paddr[CFG_IDX_LSB+CFG_IDX_W-1:CFG_IDX_LSB];

    always_comb begin
        addr_ok = 1'b1;
        rdata_d = '0;
        if (cfg_hit) begin
            rdata_d = 32'(cfg_q[cfg_idx]);
        end else begin
            unique case (paddr)
                ADDR_CMD: rdata_d = 32'(mode_q != MODE_IDLE);
                ADDR_TEMP_LIMIT: rdata_d = 32'(limit_q);
                ADDR_FAULT_SETUP: rdata_d = 32'(sel_q);
                ADDR_FAULT_STATUS: rdata_d = 32'(fs_q);
                ADDR_OT_FAULT: rdata_d = 32'(ot_q);
                ADDR_CHK_STORED: rdata_d = 32'(chk_stored_q);
                ADDR_SIG_NVM: rdata_d = 32'(NVM_SIG);
                ADDR_SIG_CALC: rdata_d = 32'(sig_calc_q);
                ADDR_REF_VOLT: rdata_d = 32'(ref_q);
                ADDR_COEF_A: rdata_d = 32'({COEF_A, 5'h00});
                ADDR_COEF_B: rdata_d = 32'({COEF_B});
                ADDR_COEF_C: rdata_d = 32'({COEF_C});
                ADDR_IRQ_STATUS: rdata_d = 32'(irq_stat_q);
                ADDR_IRQ_MASK: rdata_d = 32'(irq_mask_q);
                default: addr_ok = 1'b0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else if (psel && penable && !pready_q) begin
            pready_q <= 1'b1;
            pslverr_q <= !addr_ok;
            prdata_q <= pwrite ? '0 : rdata_d;
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Commands; checksum and load commands are dropped while busy

    assign scan_go = acc_wr && paddr == ADDR_CMD && pwdata[CMD_SCAN_BIT];
    assign calc_go = acc_wr && paddr == ADDR_CMD && pwdata[CMD_CALC_BIT]
        && mode_q == MODE_IDLE && !boot_q;
    assign check_go = acc_wr && paddr == ADDR_CMD && pwdata[CMD_CHECK_BIT]
        && mode_q == MODE_IDLE && !boot_q && !calc_go;
    assign load_go = mode_q == MODE_IDLE && (boot_q || (acc_wr &&
        paddr == ADDR_CMD && pwdata[CMD_RELOAD_BIT] && !calc_go &&
        !check_go));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_q <= 1'b1;
        end else if (load_go) begin
            boot_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= MODE_IDLE;
        end else if (eng_done) begin
            mode_q <= MODE_IDLE;
        end else if (calc_go) begin
            mode_q <= MODE_CALC;
        end else if (check_go) begin
            mode_q <= MODE_CHECK;
        end else if (load_go) begin
            mode_q <= MODE_LOAD;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Config page, memory image load and signatures

    assign eng_word = mode_q == MODE_LOAD ? NVM_IMAGE[eng_idx] :
        cfg_q[eng_idx];

    sig_engine #(
        .WORD_W(TEMP_W),
        .SIG_W(SIG_W),
        .N_WORDS(CFG_WORDS),
        .IDX_W(CFG_IDX_W),
        .POLY(SIG_POLY)
    ) u_sig (
        .clk(pclk),
        .rst_n(presetn),
        .start(calc_go || check_go || load_go),
        .word_in(eng_word),
        .idx(eng_idx),
        .busy(eng_busy),
        .done(eng_done),
        .sig(eng_sig)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < CFG_WORDS; i++) begin
                cfg_q[i] <= '0;
            end
        end else if (mode_q == MODE_LOAD && eng_busy) begin
            cfg_q[eng_idx] <= NVM_IMAGE[eng_idx];
        end else if (acc_wr && cfg_hit) begin
            cfg_q[cfg_idx] <= pwdata[TEMP_W-1:0];
        end
    end

    assign chk_fail = eng_done && mode_q == MODE_CHECK &&
        eng_sig != chk_stored_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chk_stored_q <= '0;
            sig_calc_q <= '0;
        end else if (eng_done && mode_q == MODE_CALC) begin
            chk_stored_q <= eng_sig;
        end else if (eng_done && mode_q == MODE_LOAD) begin
            sig_calc_q <= eng_sig;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Over-temperature check and settings

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            limit_q <= TEMP_LIMIT_RST;
            sel_q <= TEST_SEL_RST;
        end else if (acc_wr && paddr == ADDR_TEMP_LIMIT) begin
            limit_q <= pwdata[TEMP_W-1:0];
        end else if (acc_wr && paddr == ADDR_FAULT_SETUP) begin
            sel_q <= pwdata[N_TEMP-1:0];
        end
    end

    always_comb begin
        for (int i = 0; i < N_TEMP; i++) begin
            ot_hit[i] = scan_go && sel_q[i] &&
                adc_in.volts[i] < limit_q;
        end
    end

    assign ot_clr = acc_wr && paddr == ADDR_OT_FAULT ?
        pwdata[N_TEMP-1:0] : '0;
    assign fs_clr = acc_wr && paddr == ADDR_FAULT_STATUS ?
        pwdata[FS_W-1:0] : '0;
    assign fs_set = {chk_fail, |ot_hit};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ot_q <= '0;
            fs_q <= '0;
            ref_q <= '0;
        end else begin
            ot_q <= (ot_q & ~ot_clr) | ot_hit;
            fs_q <= (fs_q & ~fs_clr) | fs_set;
            if (scan_go) begin
                ref_q <= adc_in.ref_volt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Unsolicited fault report and interrupt

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            report_valid_q <= 1'b0;
            report_data_q <= '0;
        end else if (fs_q == '0 && fs_set != '0) begin
            report_valid_q <= 1'b1;
            report_data_q <= fs_set;
        end else if (report_ack) begin
            report_valid_q <= 1'b0;
        end
    end

    assign irq_ev = {fs_set != '0, eng_done && mode_q == MODE_LOAD,
        eng_done && mode_q != MODE_LOAD, scan_go};
    assign irq_clr = acc_rd && paddr == ADDR_IRQ_STATUS ? irq_stat_q : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= '0;
            irq_mask_q <= '0;
            irq <= 1'b0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
            if (acc_wr && paddr == ADDR_IRQ_MASK) begin
                irq_mask_q <= pwdata[IRQ_W-1:0];
            end
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    property p_ot_immediate;
        @(posedge pclk) disable iff (!presetn)
        scan_go |=> ((ot_q & $past(ot_hit)) == $past(ot_hit)) &&
            (fs_q[FS_OT_BIT] || $past(ot_hit) == '0);
    endproperty
    a_ot_immediate: assert property (p_ot_immediate)
        else $error("over-temperature not flagged at once");

    property p_full_scale;
        @(posedge pclk) disable iff (!presetn)
        (scan_go && limit_q == TEMP_FULL_SCALE && sel_q[0] &&
            adc_in.volts[0] != TEMP_FULL_SCALE) |=> ot_q[0];
    endproperty
    a_full_scale: assert property (p_full_scale)
        else $error("input below full-scale limit not flagged");

    property p_deselected;
        @(posedge pclk) disable iff (!presetn)
        (scan_go && !sel_q[1] && !ot_q[1]) |=> !ot_q[1];
    endproperty
    a_deselected: assert property (p_deselected)
        else $error("deselected input flagged");

    property p_report;
        @(posedge pclk) disable iff (!presetn)
        (fs_q == '0 && fs_set != '0) |=>
            report_valid_q && report_data_q == $past(fs_set);
    endproperty
    a_report: assert property (p_report)
        else $error("fault report not sent");

    property p_calc_store;
        @(posedge pclk) disable iff (!presetn)
        calc_go |-> ##[1:12] (eng_done && mode_q == MODE_CALC)
            ##1 chk_stored_q == $past(eng_sig);
    endproperty
    a_calc_store: assert property (p_calc_store)
        else $error("checksum not stored after calculate");

    property p_check_flag;
        @(posedge pclk) disable iff (!presetn)
        chk_fail |=> fs_q[FS_CHK_BIT];
    endproperty
    a_check_flag: assert property (p_check_flag)
        else $error("checksum mismatch not flagged");

    property p_load_sig;
        @(posedge pclk) disable iff (!presetn)
        load_go |-> ##[1:12] (eng_done && mode_q == MODE_LOAD)
            ##1 sig_calc_q == $past(eng_sig);
    endproperty
    a_load_sig: assert property (p_load_sig)
        else $error("image signature not captured after load");

    property p_coef_a;
        @(posedge pclk) disable iff (!presetn)
        (acc_rd && paddr == ADDR_COEF_A) |->
            prdata_q[TEMP_W-1:0] == {COEF_A, 5'h00} && prdata_q[31:14] == '0;
    endproperty
    a_coef_a: assert property (p_coef_a)
        else $error("coefficient A read wrong");

    property p_apb_wait;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready_q) |=> pready_q ##1 !pready_q;
    endproperty
    a_apb_wait: assert property (p_apb_wait)
        else $error("APB answer timing wrong");

    c_ot: cover property (@(posedge pclk) disable iff (!presetn)
        scan_go && ot_hit != '0);
    c_chk_fail: cover property (@(posedge pclk) disable iff (!presetn)
        chk_fail);
    c_report: cover property (@(posedge pclk) disable iff (!presetn)
        report_valid_q && report_ack);
endmodule // fault_diag
`default_nettype wire

/* File: sim/host_model.sv */
// Host-side partner: APB master task and fault report acknowledge.
// Assumes one clock pclk; the bench calls apb() by hierarchical name.
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic pclk,
    input wire logic presetn,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic report_valid,
    input wire fault_diag_pkg::fault_report_t report_data,
    output logic report_ack,
    output logic hang
);
    import fault_diag_pkg::*;
    int ack_delay = 0;
    int ack_cnt;
    int n_reports;
    fault_report_t last_report;

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        hang = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One transfer; holds the request until pready is sampled high or 50 cycles pass, then flags hang
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            hang <= 1'b1;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Acknowledge each report after ack_delay cycles and keep it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            report_ack <= 1'b0;
            ack_cnt <= 0;
            n_reports <= 0;
            last_report <= '0;
        end else if (report_ack) begin
            report_ack <= 1'b0;
            ack_cnt <= 0;
        end else if (report_valid) begin
            if (ack_cnt >= ack_delay) begin
                report_ack <= 1'b1;
                n_reports <= n_reports + 1;
                last_report <= report_data;
            end else begin
                ack_cnt <= ack_cnt + 1;
            end
        end
    end
endmodule // host_model
`default_nettype wire

/* File: sim/tb_fault_diag.sv */
// Self-checking bench of the fault diagnostic block.
// Assumes host_model as APB master and report acknowledger.
`timescale 1ns/1ps
`default_nettype none
module tb_fault_diag;
    import fault_diag_pkg::*;
    typedef struct packed {
        logic [TEMP_W-1:0] lim;
        logic [N_TEMP-1:0] sel;
        logic [N_TEMP-1:0][TEMP_W-1:0] volts;
        logic [N_TEMP-1:0] ot;
    } ot_row_t;

    function automatic logic [SIG_W-1:0] sig_of(input nvm_image_t img);
        logic [SIG_W-1:0] s;
        s = '0;
        for (int w = 0; w < CFG_WORDS; w++) begin
            s = {s[SIG_W-2:0], 1'b0} ^ (s[SIG_W-1] ? SIG_POLY : 16'h0000)
                ^ {2'b00, img[w]};
        end
        return s;
    endfunction

    localparam nvm_image_t IMAGE = {14'h0123, 14'h3fff, 14'h2000,
        14'h0001, 14'h1abc, 14'h0000, 14'h2aaa, 14'h1555};
    localparam logic [SIG_W-1:0] STORED_SIG = sig_of(IMAGE);

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic report_valid, report_ack, hang, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, d;
    adc_result_t adc_in;
    fault_report_t report_data;
    nvm_image_t cfg;
    ot_row_t rows [6];
    int num_errors, n_compared, nrep;

    fault_diag #(.NVM_IMAGE(IMAGE), .NVM_SIG(STORED_SIG), .COEF_A(9'h1fa),
        .COEF_B(14'h3fcd), .COEF_C(14'h00a4)) fault_diag_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .adc_in(adc_in), .irq(irq),
        .report_valid(report_valid), .report_data(report_data),
        .report_ack(report_ack));

    host_model host_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .report_valid(report_valid),
        .report_data(report_data), .report_ack(report_ack), .hang(hang));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] x;
        logic er;
        host_inst.apb(1'b1, a, v, x, er);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        logic er;
        host_inst.apb(1'b0, a, 32'h0, v, er);
    endtask

    task automatic end_of_test();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic wait_idle();
        logic [31:0] v;
        for (int n = 0; n < 40; n++) begin
            rd(ADDR_CMD, v);
            if (v[0] === 1'b0) return;
        end
        num_errors++;
        end_of_test();
    endtask

    task automatic wait_reports(input int n);
        for (int k = 0; k < 40; k++) begin
            if (host_inst.n_reports == n) return;
            @(posedge pclk);
            #1;
        end
        num_errors++;
        end_of_test();
    endtask

    always @(posedge hang) begin
        num_errors++;
        end_of_test();
    end

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        num_errors = 0;
        n_compared = 0;
        presetn = 1'b0;
        adc_in = '0;
        rows = '{'{14'h1000, 4'hf, {4{14'h1000}}, 4'h0},
            '{14'h1000, 4'hf, {14'h0fff, 14'h2000, 14'h2000, 14'h2000}, 4'h8},
            '{14'h1000, 4'h7, {14'h0000, 14'h2000, 14'h2000, 14'h0fff}, 4'h1},
            '{14'h3fff, 4'h5, {14'h3ffe, 14'h3fff, 14'h3fff, 14'h3ffe}, 4'h1},
            '{14'h0000, 4'hf, {4{14'h0000}}, 4'h0},
            '{14'h2000, 4'ha, {4{14'h0000}}, 4'ha}};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        wait_idle();
        rd(ADDR_SIG_CALC, d);
        check("sig_calc", d, {16'h0, STORED_SIG});
        rd(ADDR_SIG_NVM, d);
        check("sig_nvm", d, {16'h0, STORED_SIG});
        for (int w = 0; w < CFG_WORDS; w++) begin
            rd(ADDR_CFG_BASE + 8'(4 * w), d);
            check("cfg_boot", d, {18'h0, IMAGE[w]});
        end
        rd(ADDR_TEMP_LIMIT, d);
        check("limit_rst", d, {18'h0, TEMP_LIMIT_RST});
        rd(ADDR_FAULT_SETUP, d);
        check("sel_rst", d, {28'h0, TEST_SEL_RST});
        rd(ADDR_COEF_A, d);
        check("coef_a", d, 32'h3f40);
        rd(ADDR_COEF_B, d);
        check("coef_b", d, 32'h3fcd);
        rd(ADDR_COEF_C, d);
        check("coef_c", d, 32'h00a4);
        host_inst.apb(1'b0, 8'h38, 32'h0, d, e);
        check("unmapped", {e, d[30:0]}, 32'h8000_0000);
        // Over-temperature table, host keeps summary-then-detail order
        for (int i = 0; i < 6; i++) begin
            wr(ADDR_TEMP_LIMIT, {18'h0, rows[i].lim});
            wr(ADDR_FAULT_SETUP, {28'h0, rows[i].sel});
            adc_in <= '{volts: rows[i].volts, ref_volt: 14'h20a7 + 14'(i)};
            nrep = host_inst.n_reports;
            wr(ADDR_CMD, 32'h1 << CMD_SCAN_BIT);
            rd(ADDR_FAULT_STATUS, d);
            check("summary", d, {31'h0, |rows[i].ot});
            if (d[FS_OT_BIT] === 1'b1) begin
                rd(ADDR_OT_FAULT, d);
                check("ot_fault", d, {28'h0, rows[i].ot});
                wait_reports(nrep + 1);
                check("report", {30'h0, host_inst.last_report}, 32'h1);
                wr(ADDR_OT_FAULT, 32'hf);
                wr(ADDR_FAULT_STATUS, 32'h3);
            end
            rd(ADDR_REF_VOLT, d);
            check("ref_volt", d, {18'h0, 14'h20a7 + 14'(i)});
        end
        // Fault while summary is already set: no second report
        host_inst.ack_delay = 6;
        wr(ADDR_FAULT_SETUP, 32'hf);
        wr(ADDR_TEMP_LIMIT, 32'h1000);
        adc_in <= '{volts: {4{14'h0800}}, ref_volt: 14'h0000};
        nrep = host_inst.n_reports;
        wr(ADDR_CMD, 32'h1 << CMD_SCAN_BIT);
        wait_reports(nrep + 1);
        wr(ADDR_CMD, 32'h1 << CMD_SCAN_BIT);
        rd(ADDR_FAULT_STATUS, d);
        check("reports", 32'(host_inst.n_reports), 32'(nrep + 1));
        check("fs_held", d, 32'h1);
        check("no_report", {31'h0, report_valid}, 32'h0);
        wr(ADDR_OT_FAULT, 32'hf);
        wr(ADDR_FAULT_STATUS, 32'h3);
        // Configuration checksum
        cfg = IMAGE;
        cfg[2] = 14'h1234;
        for (int w = 0; w < CFG_WORDS; w++) begin
            wr(ADDR_CFG_BASE + 8'(4 * w), {18'h0, cfg[w]});
            rd(ADDR_CFG_BASE + 8'(4 * w), d);
            check("cfg_rb", d, {18'h0, cfg[w]});
        end
        wr(ADDR_CMD, 32'h1 << CMD_CALC_BIT);
        wait_idle();
        rd(ADDR_CHK_STORED, d);
        check("chk_stored", d, {16'h0, sig_of(cfg)});
        wr(ADDR_CMD, 32'h1 << CMD_CHECK_BIT);
        wait_idle();
        rd(ADDR_FAULT_STATUS, d);
        check("chk_clean", d, 32'h0);
        wr(ADDR_CFG_BASE + 8'h1c, 32'h0abc);
        nrep = host_inst.n_reports;
        wr(ADDR_CMD, 32'h1 << CMD_CHECK_BIT);
        wait_idle();
        rd(ADDR_FAULT_STATUS, d);
        check("chk_fault", d, 32'h1 << FS_CHK_BIT);
        wait_reports(nrep + 1);
        check("chk_report", {30'h0, host_inst.last_report}, 32'h2);
        wr(ADDR_CFG_BASE + 8'h1c, {18'h0, cfg[7]});
        wr(ADDR_FAULT_STATUS, 32'h3);
        wr(ADDR_CMD, 32'h1 << CMD_CHECK_BIT);
        wait_idle();
        rd(ADDR_FAULT_STATUS, d);
        check("chk_restored", d, 32'h0);
        // Reload command reloads the page and recomputes the signature
        wr(ADDR_CMD, 32'h1 << CMD_RELOAD_BIT);
        wait_idle();
        rd(ADDR_CFG_BASE + 8'h08, d);
        check("cfg_reload", d, {18'h0, IMAGE[2]});
        rd(ADDR_SIG_CALC, d);
        check("sig_reload", d, {16'h0, STORED_SIG});
        // Interrupt raised, read-cleared, then masked
        wr(ADDR_FAULT_SETUP, 32'h0);
        rd(ADDR_IRQ_STATUS, d);
        wr(ADDR_IRQ_MASK, 32'h1 << IRQ_SCAN_BIT);
        wr(ADDR_CMD, 32'h1 << CMD_SCAN_BIT);
        repeat (2) @(posedge pclk);
        #1;
        check("irq_on", {31'h0, irq}, 32'h1);
        rd(ADDR_IRQ_STATUS, d);
        check("irq_status", d, 32'h1 << IRQ_SCAN_BIT);
        repeat (2) @(posedge pclk);
        #1;
        check("irq_off", {31'h0, irq}, 32'h0);
        wr(ADDR_IRQ_MASK, 32'h0);
        wr(ADDR_CMD, 32'h1 << CMD_SCAN_BIT);
        repeat (2) @(posedge pclk);
        #1;
        check("irq_masked", {31'h0, irq}, 32'h0);
        // Second reset in mid-run restores register defaults
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        wait_idle();
        rd(ADDR_TEMP_LIMIT, d);
        check("limit_rst2", d, {18'h0, TEMP_LIMIT_RST});
        end_of_test();
    end
endmodule // tb_fault_diag
`default_nettype wire
